//--- design/synth_pll_control_regs.v
// Purpose: Control registers for resync delay, modulator, amplitude, power and lock detection.
// Assumes: Phase detector, window and divided clocks arrive as asynchronous pins.
// Notes: All outputs are registered one cycle after the register or event that drives them.
`include "synth_pll_map.vh"

module synth_pll_control_regs #(
  parameter SDM_W = 25
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // Serial register port
  input wire i_spi_sclk,
  input wire i_spi_cs_n,
  input wire i_spi_mosi,
  output wire o_spi_miso,
  output wire o_spi_miso_oe,
  // Analog and divider pins
  input wire i_pfd_clk,
  input wire i_phase_in_window,
  input wire i_fb_div_clk,
  input wire i_ref_div_clk,
  // Neighbouring register logic
  input wire i_resync_trigger,
  input wire [15:0] i_resync_delay_count_low,
  input wire [7:0] i_phase_adjust,
  input wire [SDM_W-1:0] i_sdm_frac,
  // Resync
  output reg o_resync_apply,
  output reg o_resync_busy,
  // Modulator
  output reg [SDM_W-1:0] o_sdm_frac,
  output reg o_sdm_lsb_increment,
  output reg o_aux_sdm_enable,
  // Output amplitude
  output reg [3:0] o_out1_amplitude,
  output reg [3:0] o_out2_amplitude,
  // Phase adjustment
  output reg o_phase_shift_sign,
  output reg [8:0] o_phase_step,
  // Power down
  output reg o_chip_powerdown,
  output reg o_sync_powerdown,
  output reg o_refdet_powerdown,
  output reg o_lockdet_powerdown,
  output reg o_out1_buffer_powerdown,
  output reg o_out2_buffer_powerdown,
  // Lock detector
  output reg [2:0] o_lock_window_width,
  output reg o_lock_window_enable,
  output reg o_loss_lock_enable,
  output reg o_lock_indication,
  // Gated divided clocks
  output reg o_feedback_div_clk,
  output reg o_reference_div_clk
);
  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------
  wire [6:0] pins_s;

  pin_sync #(
    .W(7)
  ) u_pin_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async({i_spi_sclk, i_spi_cs_n, i_spi_mosi, i_pfd_clk, i_phase_in_window,
      i_fb_div_clk, i_ref_div_clk}),
    .o_sync(pins_s)
  );

  wire sclk_s = pins_s[6];
  wire cs_n_s = pins_s[5];
  wire mosi_s = pins_s[4];
  wire pfd_s = pins_s[3];
  wire in_window_s = pins_s[2];
  wire fb_clk_s = pins_s[1];
  wire ref_clk_s = pins_s[0];

  // ------------------------------------------------------------
  // Serial register port
  // ------------------------------------------------------------
  wire [6:0] reg_addr;
  wire reg_wr_en;
  wire [7:0] reg_wr_data;
  reg [7:0] reg_rd_data;

  spi_byte_port u_spi (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_sclk_s(sclk_s),
    .i_cs_n_s(cs_n_s),
    .i_mosi_s(mosi_s),
    .i_rd_data(reg_rd_data),
    .o_addr(reg_addr),
    .o_wr_en(reg_wr_en),
    .o_wr_data(reg_wr_data),
    .o_miso(o_spi_miso),
    .o_miso_oe(o_spi_miso_oe)
  );

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  reg [7:0] resync_delay_count_top_byte_r;
  reg [7:0] modulator_options_r;
  reg [7:0] output_amplitude_r;
  reg [7:0] phase_sign_and_detector_power_r;
  reg [7:0] power_control_r;
  reg [7:0] lock_timing_r;
  reg [7:0] lock_and_clock_gating_r;

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      resync_delay_count_top_byte_r <= `ZERO_RST;
      modulator_options_r <= `ZERO_RST;
      output_amplitude_r <= `ZERO_RST;
      phase_sign_and_detector_power_r <= `PHASE_PWR_RST;
      power_control_r <= `POWER_RST;
      lock_timing_r <= `ZERO_RST;
      lock_and_clock_gating_r <= `ZERO_RST;
    end else if (reg_wr_en) begin
      case (reg_addr)
        `RESYNC_TOP_ADDR: resync_delay_count_top_byte_r <= reg_wr_data;
        `MOD_OPTS_ADDR: modulator_options_r <= reg_wr_data;
        `AMP_ADDR: output_amplitude_r <= reg_wr_data;
        `PHASE_PWR_ADDR: phase_sign_and_detector_power_r <= reg_wr_data;
        `POWER_ADDR: power_control_r <= reg_wr_data;
        `LOCK_TIME_ADDR: lock_timing_r <= reg_wr_data;
        `LOCK_GATE_ADDR: lock_and_clock_gating_r <= reg_wr_data;
        default: begin
        end
      endcase
    end
  end

  // Reads return every stored bit; unmapped addresses read zero.
  always @* begin
    case (reg_addr)
      `RESYNC_TOP_ADDR: reg_rd_data = resync_delay_count_top_byte_r;
      `MOD_OPTS_ADDR: reg_rd_data = modulator_options_r;
      `AMP_ADDR: reg_rd_data = output_amplitude_r;
      `PHASE_PWR_ADDR: reg_rd_data = phase_sign_and_detector_power_r;
      `POWER_ADDR: reg_rd_data = power_control_r;
      `LOCK_TIME_ADDR: reg_rd_data = lock_timing_r;
      `LOCK_GATE_ADDR: reg_rd_data = lock_and_clock_gating_r;
      default: reg_rd_data = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------
  wire chip_pd = power_control_r[`CHIP_PD_BIT];
  wire sync_pd = phase_sign_and_detector_power_r[`SYNC_PD_BIT] | chip_pd;
  wire lockdet_pd = power_control_r[`LOCKDET_PD_BIT] | chip_pd;
  wire [4:0] lock_cycle_count = lock_timing_r[`LCNT_MSB:`LCNT_LSB];
  wire lock_window_enable = lock_and_clock_gating_r[`LWIN_EN_BIT];
  wire loss_lock_enable = lock_and_clock_gating_r[`LOL_EN_BIT];
  wire lockdet_clear = lock_and_clock_gating_r[`LD_CLEAR_BIT];
  wire phase_shift_sign = phase_sign_and_detector_power_r[`PHASE_SIGN_BIT];

  // Phase detector period tick from the synchronised phase detector clock.
  reg pfd_d_r;
  wire pfd_tick = pfd_s & ~pfd_d_r;

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pfd_d_r <= 1'b0;
    end else begin
      pfd_d_r <= pfd_s;
    end
  end

  // ------------------------------------------------------------
  // Resynchronization delay
  // ------------------------------------------------------------
  localparam RS_IDLE = 2'b00;
  localparam RS_WAIT = 2'b01;
  localparam RS_APPLY = 2'b10;

  reg [1:0] rs_state_r;
  reg [1:0] rs_state_nxt;
  reg [23:0] rs_count_r;
  reg [23:0] rs_count_nxt;

  always @* begin
    rs_state_nxt = rs_state_r;
    rs_count_nxt = rs_count_r;
    case (rs_state_r)
      RS_IDLE: begin
        if (i_resync_trigger && !sync_pd) begin
          rs_count_nxt = {resync_delay_count_top_byte_r, i_resync_delay_count_low};
          if ({resync_delay_count_top_byte_r, i_resync_delay_count_low} == 24'h000000) begin
            rs_state_nxt = RS_APPLY;
          end else begin
            rs_state_nxt = RS_WAIT;
          end
        end
      end
      RS_WAIT: begin
        if (sync_pd) begin
          rs_state_nxt = RS_IDLE;
        end else if (pfd_tick) begin
          rs_count_nxt = rs_count_r - 24'h000001;
          if (rs_count_r == 24'h000001) begin
            rs_state_nxt = RS_APPLY;
          end
        end
      end
      RS_APPLY: begin
        rs_state_nxt = RS_IDLE;
      end
      default: begin
        rs_state_nxt = RS_IDLE;
      end
    endcase
  end

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rs_state_r <= RS_IDLE;
      rs_count_r <= 24'h000000;
    end else begin
      rs_state_r <= rs_state_nxt;
      rs_count_r <= rs_count_nxt;
    end
  end

  // ------------------------------------------------------------
  // Lock detector
  // ------------------------------------------------------------
  reg [20:0] lock_cycle_count_r;
  reg ld_locked_r;
  wire [20:0] ld_base = lock_cycle_count[0] ? `LOCK_BASE_ODD : `LOCK_BASE_EVEN;
  wire [20:0] ld_target = (ld_base << lock_cycle_count[4:1]) + `LOCK_OFFSET;
  wire ld_hold = lockdet_pd | lockdet_clear;
  wire ld_miss = lock_window_enable & ~in_window_s;

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lock_cycle_count_r <= 21'h000000;
      ld_locked_r <= 1'b0;
    end else if (ld_hold) begin
      lock_cycle_count_r <= 21'h000000;
      ld_locked_r <= 1'b0;
    end else if (pfd_tick) begin
      if (ld_miss) begin
        lock_cycle_count_r <= 21'h000000;
        if (loss_lock_enable) begin
          ld_locked_r <= 1'b0;
        end
      end else if (!ld_locked_r) begin
        if (lock_cycle_count_r + 21'h000001 >= ld_target) begin
          ld_locked_r <= 1'b1;
        end else begin
          lock_cycle_count_r <= lock_cycle_count_r + 21'h000001;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Modulator and phase arithmetic
  // ------------------------------------------------------------
  wire sdm_inc = modulator_options_r[`SDM_LSB_INC_BIT];
  wire [SDM_W-1:0] sdm_sum = i_sdm_frac + {{(SDM_W-1){1'b0}}, sdm_inc};
  // The adjustment code already carries degrees scaled by 4096 over 360.
  wire [8:0] phase_mag = {1'b0, i_phase_adjust};
  wire [8:0] phase_signed = phase_shift_sign ? (9'h000 - phase_mag) : phase_mag;

  // ------------------------------------------------------------
  // Output stage
  // ------------------------------------------------------------
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_resync_apply <= 1'b0;
      o_resync_busy <= 1'b0;
      o_sdm_frac <= {SDM_W{1'b0}};
      o_sdm_lsb_increment <= 1'b0;
      o_aux_sdm_enable <= 1'b0;
      o_out1_amplitude <= 4'h0;
      o_out2_amplitude <= 4'h0;
      o_phase_shift_sign <= 1'b0;
      o_phase_step <= 9'h000;
      o_chip_powerdown <= 1'b1;
      o_sync_powerdown <= 1'b1;
      o_refdet_powerdown <= 1'b1;
      o_lockdet_powerdown <= 1'b1;
      o_out1_buffer_powerdown <= 1'b1;
      o_out2_buffer_powerdown <= 1'b1;
      o_lock_window_width <= 3'h0;
      o_lock_window_enable <= 1'b0;
      o_loss_lock_enable <= 1'b0;
      o_lock_indication <= 1'b0;
      o_feedback_div_clk <= 1'b0;
      o_reference_div_clk <= 1'b0;
    end else begin
      o_resync_apply <= (rs_state_r == RS_APPLY);
      o_resync_busy <= (rs_state_r != RS_IDLE);
      o_sdm_frac <= sdm_sum;
      o_sdm_lsb_increment <= sdm_inc;
      o_aux_sdm_enable <= modulator_options_r[`AUX_SDM_BIT];
      o_out1_amplitude <= output_amplitude_r[`OUT1_AMP_MSB:`OUT1_AMP_LSB];
      o_out2_amplitude <= output_amplitude_r[`OUT2_AMP_MSB:`OUT2_AMP_LSB];
      o_phase_shift_sign <= phase_shift_sign;
      o_phase_step <= phase_signed;
      o_chip_powerdown <= chip_pd;
      o_sync_powerdown <= sync_pd;
      o_refdet_powerdown <= phase_sign_and_detector_power_r[`REFDET_PD_BIT] | chip_pd;
      o_lockdet_powerdown <= lockdet_pd;
      o_out1_buffer_powerdown <= power_control_r[`OUT1_PD_BIT] | chip_pd;
      o_out2_buffer_powerdown <= power_control_r[`OUT2_PD_BIT] | chip_pd;
      o_lock_window_width <= lock_timing_r[`LWIN_W_MSB:`LWIN_W_LSB];
      o_lock_window_enable <= lock_window_enable;
      o_loss_lock_enable <= loss_lock_enable;
      o_lock_indication <= ld_locked_r & ~ld_hold;
      o_feedback_div_clk <= fb_clk_s & lock_and_clock_gating_r[`FB_GATE_BIT];
      o_reference_div_clk <= ref_clk_s & lock_and_clock_gating_r[`REF_GATE_BIT];
    end
  end
endmodule

//--- design/synth_pll_map.vh
// Purpose: Register offsets, field positions, reset values and lock timing constants.
// Assumes: Byte-wide registers, 7-bit register address carried by the serial port.
// Notes: Included by the control register block.
//
// Overview of operation
// - Hold resync delay bits 23:16; wait then apply.
// - Sdm lsb increment bit adds one to modulator.
// - Out2 amplitude from bits 7:4, 0000 min.
// - Out1 amplitude from bits 3:0, 0000 min.
// - Phase sign 0 adds, 1 subtracts adjustment.
// - Sync powerdown bit powers down sync circuitry.
// - Refdet powerdown bit resets to one, active high.
// - Power control register resets to 0x83.
// - Lockdet powerdown bit powers down lock detector.
// - Bit 1 powers down out1 buffer, resets one.
// - Bit 0 powers down out2 buffer, resets one.
// - Lock rises after 24/32 times power of two, plus three.
// - Lock window width from lock timing bits 7:5.
// - Lock window used only while enable bit set.
// - Feedback divided clock passes only when bit 7.
// - Reference divided clock passes only when bit 6.
// - Lockdet clear bit forces unlocked state while set.
// - Phase code equals degrees times 4096 over 360.
`ifndef SYNTH_PLL_MAP_VH
`define SYNTH_PLL_MAP_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define RESYNC_TOP_ADDR 7'h27
`define MOD_OPTS_ADDR 7'h28
`define AMP_ADDR 7'h29
`define PHASE_PWR_ADDR 7'h2A
`define POWER_ADDR 7'h2B
`define LOCK_TIME_ADDR 7'h2C
`define LOCK_GATE_ADDR 7'h2D

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define ZERO_RST 8'h00
`define PHASE_PWR_RST 8'h04
`define POWER_RST 8'h83

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SDM_LSB_INC_BIT 6
`define AUX_SDM_BIT 5
`define OUT2_AMP_MSB 7
`define OUT2_AMP_LSB 4
`define OUT1_AMP_MSB 3
`define OUT1_AMP_LSB 0
`define PHASE_SIGN_BIT 6
`define SYNC_PD_BIT 4
`define REFDET_PD_BIT 2
`define CHIP_PD_BIT 7
`define LOCKDET_PD_BIT 3
`define OUT1_PD_BIT 1
`define OUT2_PD_BIT 0
`define LWIN_W_MSB 7
`define LWIN_W_LSB 5
`define LCNT_MSB 4
`define LCNT_LSB 0
`define FB_GATE_BIT 7
`define REF_GATE_BIT 6
`define LOL_EN_BIT 5
`define LWIN_EN_BIT 4
`define LD_CLEAR_BIT 2

// ------------------------------------------------------------
// Lock timing
// ------------------------------------------------------------
`define LOCK_BASE_EVEN 21'h00018
`define LOCK_BASE_ODD 21'h00020
`define LOCK_OFFSET 21'h00003

`endif

//--- design/pin_sync.v
// Purpose: Two flip-flop synchroniser for a group of asynchronous inputs.
// Assumes: Each bit is an independent level.
// Notes: Only the second stage may be read by other logic.
module pin_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // Levels
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;
endmodule

//--- design/spi_byte_port.v
// Purpose: Serial register port, mode 0, instruction byte then data byte.
// Assumes: Synchronised pins; serial clock at most one eighth of the system clock.
// Notes: Instruction bit 7 high reads, low writes; bits 6:0 address.
module spi_byte_port (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // Synchronised pins
  input wire i_sclk_s,
  input wire i_cs_n_s,
  input wire i_mosi_s,
  // Register side
  input wire [7:0] i_rd_data,
  output wire [6:0] o_addr,
  output wire o_wr_en,
  output wire [7:0] o_wr_data,
  // Serial data out
  output wire o_miso,
  output wire o_miso_oe
);
  reg sclk_d_r;
  reg [4:0] cnt_r;
  reg [7:0] shift_r;
  reg [7:0] out_r;
  reg rd_r;
  reg [6:0] addr_r;
  reg wr_r;
  reg [7:0] wdata_r;
  reg miso_r;
  reg oe_r;
  wire rise = i_sclk_s & ~sclk_d_r;
  wire fall = ~i_sclk_s & sclk_d_r;

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_d_r <= 1'b0;
      cnt_r <= 5'h00;
      shift_r <= 8'h00;
      out_r <= 8'h00;
      rd_r <= 1'b0;
      addr_r <= 7'h00;
      wr_r <= 1'b0;
      wdata_r <= 8'h00;
      miso_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      sclk_d_r <= i_sclk_s;
      wr_r <= 1'b0;
      if (i_cs_n_s) begin
        cnt_r <= 5'h00;
        oe_r <= 1'b0;
      end else if (rise && cnt_r < 5'h10) begin
        shift_r <= {shift_r[6:0], i_mosi_s};
        cnt_r <= cnt_r + 5'h01;
        if (cnt_r == 5'h07) begin
          rd_r <= shift_r[6];
          addr_r <= {shift_r[5:0], i_mosi_s};
        end
        if (cnt_r == 5'h0F && !rd_r) begin
          wr_r <= 1'b1;
          wdata_r <= {shift_r[6:0], i_mosi_s};
        end
      end else if (fall && rd_r && cnt_r == 5'h08) begin
        miso_r <= i_rd_data[7];
        out_r <= {i_rd_data[6:0], 1'b0};
        oe_r <= 1'b1;
      end else if (fall && rd_r && cnt_r > 5'h08) begin
        miso_r <= out_r[7];
        out_r <= {out_r[6:0], 1'b0};
      end
    end
  end

  assign o_addr = addr_r;
  assign o_wr_en = wr_r;
  assign o_wr_data = wdata_r;
  assign o_miso = miso_r;
  assign o_miso_oe = oe_r;
endmodule

//--- bench/synth_pll_control_regs_sva.sv
// Purpose: Port-level checks of the control register block.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Bound to every instance of the block.
module synth_pll_control_regs_sva #(
  parameter SDM_W = 25
) (
  // Clock, reset and inputs
  input wire logic i_mclk, i_rst_n, i_fb_div_clk, i_ref_div_clk, i_resync_trigger,
  input wire logic [7:0] i_phase_adjust,
  input wire logic [SDM_W-1:0] i_sdm_frac,
  // Outputs
  input wire logic o_resync_apply, o_resync_busy, o_sdm_lsb_increment, o_phase_shift_sign,
  input wire logic [SDM_W-1:0] o_sdm_frac,
  input wire logic [8:0] o_phase_step,
  input wire logic o_chip_powerdown, o_sync_powerdown, o_refdet_powerdown, o_lockdet_powerdown,
  input wire logic o_out1_buffer_powerdown, o_out2_buffer_powerdown, o_lock_indication,
  input wire logic o_feedback_div_clk, o_reference_div_clk
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // Cycles since the lock detector was last powered down.
  logic [7:0] quiet_r;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) quiet_r <= 8'h00;
    else if (o_lockdet_powerdown) quiet_r <= 8'h00;
    else if (quiet_r != 8'hFF) quiet_r <= quiet_r + 8'h01;
  end
  property p_chip_pd; o_chip_powerdown |-> o_sync_powerdown && o_refdet_powerdown &&
    o_lockdet_powerdown && o_out1_buffer_powerdown && o_out2_buffer_powerdown; endproperty
  property p_ld_pd; o_lockdet_powerdown |=> !o_lock_indication; endproperty
  property p_sdm; $past(i_rst_n) && $stable(o_sdm_lsb_increment) |->
    o_sdm_frac == SDM_W'($past(i_sdm_frac) + o_sdm_lsb_increment); endproperty
  property p_phase; $past(i_rst_n) && $stable(o_phase_shift_sign) |-> o_phase_step ==
    (o_phase_shift_sign ? 9'(-{1'b0, $past(i_phase_adjust)}) : {1'b0, $past(i_phase_adjust)});
  endproperty
  property p_fb; (!i_fb_div_clk) [*5] |-> !o_feedback_div_clk; endproperty
  property p_ref; (!i_ref_div_clk) [*5] |-> !o_reference_div_clk; endproperty
  property p_lock_min; $rose(o_lock_indication) |-> quiet_r >= 8'h32; endproperty
  property p_busy; $rose(o_resync_busy) |-> $past(i_resync_trigger) ||
    $past(i_resync_trigger, 2); endproperty
  property p_sync_pd; o_sync_powerdown && $past(o_sync_powerdown) |-> !o_resync_apply;
  endproperty
  a_chip_pd: assert property (p_chip_pd) else $error("chip powerdown not spread");
  a_ld_pd: assert property (p_ld_pd) else $error("lock held while powered down");
  a_sdm: assert property (p_sdm) else $error("modulator fraction wrong");
  a_phase: assert property (p_phase) else $error("phase step wrong");
  a_fb: assert property (p_fb) else $error("feedback clock leaks");
  a_ref: assert property (p_ref) else $error("reference clock leaks");
  a_lock_min: assert property (p_lock_min) else $error("lock rose too soon");
  a_busy: assert property (p_busy) else $error("busy without trigger");
  a_sync_pd: assert property (p_sync_pd) else $error("apply while sync off");
  c_lock: cover property ($rose(o_lock_indication));
  c_apply: cover property (o_resync_apply);
  c_inc: cover property (o_sdm_lsb_increment);
endmodule

bind synth_pll_control_regs synth_pll_control_regs_sva #(.SDM_W(SDM_W)) u_sva (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_fb_div_clk(i_fb_div_clk),
  .i_ref_div_clk(i_ref_div_clk), .i_resync_trigger(i_resync_trigger),
  .i_phase_adjust(i_phase_adjust), .i_sdm_frac(i_sdm_frac), .o_resync_apply(o_resync_apply),
  .o_resync_busy(o_resync_busy), .o_sdm_lsb_increment(o_sdm_lsb_increment),
  .o_phase_shift_sign(o_phase_shift_sign), .o_sdm_frac(o_sdm_frac),
  .o_phase_step(o_phase_step), .o_chip_powerdown(o_chip_powerdown),
  .o_sync_powerdown(o_sync_powerdown), .o_refdet_powerdown(o_refdet_powerdown),
  .o_lockdet_powerdown(o_lockdet_powerdown), .o_out1_buffer_powerdown(o_out1_buffer_powerdown),
  .o_out2_buffer_powerdown(o_out2_buffer_powerdown), .o_lock_indication(o_lock_indication),
  .o_feedback_div_clk(o_feedback_div_clk), .o_reference_div_clk(o_reference_div_clk));

//--- bench/synth_pll_control_regs_tb.sv
// Purpose: Self-checking bench for the control register block.
// Assumes: Serial port frames of instruction then data byte.
// Notes: Inputs change on the falling clock edge.
module synth_pll_control_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Signals and instance
  // ------------------------------------------------------------
  logic i_mclk = 1'b0, i_rst_n = 1'b0, i_spi_sclk = 1'b0, i_spi_cs_n = 1'b1, i_spi_mosi = 1'b0;
  logic i_phase_in_window = 1'b1, i_resync_trigger = 1'b0;
  logic [15:0] i_resync_delay_count_low = 16'h0000;
  logic [7:0] i_phase_adjust = 8'h00, tick_r = 8'h00;
  logic [24:0] i_sdm_frac = 25'h0000000;
  wire o_spi_miso, o_spi_miso_oe, o_resync_apply, o_resync_busy, o_sdm_lsb_increment;
  wire o_aux_sdm_enable, o_phase_shift_sign, o_chip_powerdown, o_sync_powerdown;
  wire o_refdet_powerdown, o_lockdet_powerdown, o_out1_buffer_powerdown, o_out2_buffer_powerdown;
  wire o_lock_window_enable, o_loss_lock_enable, o_lock_indication;
  wire o_feedback_div_clk, o_reference_div_clk;
  wire [24:0] o_sdm_frac;
  wire [3:0] o_out1_amplitude, o_out2_amplitude;
  wire [8:0] o_phase_step;
  wire [2:0] o_lock_window_width;
  int fail_count = 0;
  int num_checks = 0;
  synth_pll_control_regs #(.SDM_W(25)) dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_spi_sclk(i_spi_sclk), .i_spi_cs_n(i_spi_cs_n), .i_spi_mosi(i_spi_mosi),
    .o_spi_miso(o_spi_miso), .o_spi_miso_oe(o_spi_miso_oe), .i_pfd_clk(tick_r[2]),
    .i_phase_in_window(i_phase_in_window), .i_fb_div_clk(tick_r[3]), .i_ref_div_clk(tick_r[2]),
    .i_resync_trigger(i_resync_trigger), .i_resync_delay_count_low(i_resync_delay_count_low),
    .i_phase_adjust(i_phase_adjust), .i_sdm_frac(i_sdm_frac), .o_resync_apply(o_resync_apply),
    .o_resync_busy(o_resync_busy), .o_sdm_frac(o_sdm_frac),
    .o_sdm_lsb_increment(o_sdm_lsb_increment), .o_aux_sdm_enable(o_aux_sdm_enable),
    .o_out1_amplitude(o_out1_amplitude), .o_out2_amplitude(o_out2_amplitude),
    .o_phase_shift_sign(o_phase_shift_sign), .o_phase_step(o_phase_step),
    .o_chip_powerdown(o_chip_powerdown), .o_sync_powerdown(o_sync_powerdown),
    .o_refdet_powerdown(o_refdet_powerdown), .o_lockdet_powerdown(o_lockdet_powerdown),
    .o_out1_buffer_powerdown(o_out1_buffer_powerdown),
    .o_out2_buffer_powerdown(o_out2_buffer_powerdown),
    .o_lock_window_width(o_lock_window_width), .o_lock_window_enable(o_lock_window_enable),
    .o_loss_lock_enable(o_loss_lock_enable), .o_lock_indication(o_lock_indication),
    .o_feedback_div_clk(o_feedback_div_clk), .o_reference_div_clk(o_reference_div_clk));
  initial begin
    forever #4 i_mclk = ~i_mclk;
  end
  always @(negedge i_mclk) tick_r <= tick_r + 8'h01;
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task automatic close_out();
    if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string name, input logic [24:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic spi(input logic [7:0] ins, dat, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {ins, dat};
    rd = 8'h00;
    i_spi_cs_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      i_spi_mosi = sh[15-i];
      cyc(5);
      i_spi_sclk = 1'b1;
      if (i > 7) rd = {rd[6:0], o_spi_miso};
      cyc(5);
      i_spi_sclk = 1'b0;
    end
    cyc(5);
    i_spi_cs_n = 1'b1;
    cyc(8);
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] unused;
    spi({1'b0, a[6:0]}, d, unused);
  endtask
  task automatic rdc(input logic [7:0] a, exp);
    logic [7:0] v;
    spi({1'b1, a[6:0]}, 8'h00, v);
    chk($sformatf("register %h", a), {17'h0, exp}, {17'h0, v});
  endtask
  task automatic wait_on(input int sel, input int lim);
    int n;
    n = 0;
    num_checks++;
    while ((sel ? o_resync_apply : o_lock_indication) !== 1'b1) begin
      cyc(1);
      n++;
      if (n > lim) begin
        fail_count++;
        $display("ERROR wait %0d expected 1 seen 0", sel);
        close_out();
      end
    end
  endtask
  function automatic logic [24:0] pd();
    return {18'h0, o_spi_miso_oe, o_chip_powerdown, o_sync_powerdown, o_refdet_powerdown,
      o_lockdet_powerdown, o_out1_buffer_powerdown, o_out2_buffer_powerdown};
  endfunction
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h83, 8'h00, 8'h00};
    chk("powerdowns", 25'h3F, pd());
    for (int a = 0; a < 7; a++) rdc(8'(8'h27 + a), rv[a]);
  endtask
  task automatic t_regs();
    for (int a = 0; a < 7; a++) wr(8'(8'h27 + a), 8'(8'hA5 ^ a));
    for (int a = 0; a < 7; a++) rdc(8'(8'h27 + a), 8'(8'hA5 ^ a));
    chk("amplitude", 25'hA7, {17'h0, o_out2_amplitude, o_out1_amplitude});
    chk("window", 25'h56, {18'h0, o_lock_window_width, o_lock_window_enable,
      o_loss_lock_enable, o_aux_sdm_enable, o_sdm_lsb_increment});
    wr(8'h29, 8'h0F);
    chk("amplitude", 25'h0F, {17'h0, o_out2_amplitude, o_out1_amplitude});
  endtask
  task automatic t_power();
    logic [7:0] r2a [4] = '{8'h10, 8'h00, 8'h00, 8'h00};
    logic [7:0] r2b [4] = '{8'h00, 8'h08, 8'h02, 8'h01};
    logic [5:0] ex [4] = '{6'h10, 6'h04, 6'h02, 6'h01};
    for (int k = 0; k < 4; k++) begin
      wr(8'h2A, r2a[k]);
      wr(8'h2B, r2b[k]);
      chk("powerdowns", {19'h0, ex[k]}, pd());
    end
  endtask
  task automatic t_sdm();
    wr(8'h28, 8'h40);
    i_sdm_frac = 25'h1FFFFFF;
    cyc(3);
    chk("fraction", 25'h0000000, o_sdm_frac);
    i_sdm_frac = 25'h0123456;
    cyc(3);
    chk("fraction", 25'h0123457, o_sdm_frac);
    wr(8'h28, 8'h00);
    chk("fraction", 25'h0123456, o_sdm_frac);
  endtask
  task automatic t_phase();
    i_phase_adjust = 8'h5B;
    wr(8'h2A, 8'h00);
    chk("phase step", 25'h05B, {15'h0, o_phase_shift_sign, o_phase_step});
    wr(8'h2A, 8'h40);
    chk("phase step", 25'h3A5, {15'h0, o_phase_shift_sign, o_phase_step});
  endtask
  task automatic t_gate();
    logic fbs, rfs;
    for (int k = 0; k < 2; k++) begin
      wr(8'h2D, k ? 8'h40 : 8'h80);
      fbs = 1'b0;
      rfs = 1'b0;
      repeat (64) begin
        cyc(1);
        fbs = fbs | o_feedback_div_clk;
        rfs = rfs | o_reference_div_clk;
      end
      chk("feedback clock", {24'h0, k == 0}, {24'h0, fbs});
      chk("reference clock", {24'h0, k == 1}, {24'h0, rfs});
    end
  endtask
  task automatic t_lock();
    wr(8'h2B, 8'h00);
    wr(8'h2A, 8'h00);
    wr(8'h2C, 8'h00);
    wr(8'h2D, 8'h04);
    chk("lock", 25'h0, o_lock_indication);
    wr(8'h2D, 8'h00);
    cyc(176);
    chk("lock", 25'h0, o_lock_indication);
    wait_on(0, 80);
    wr(8'h2D, 8'h04);
    chk("lock", 25'h0, o_lock_indication);
    i_phase_in_window = 1'b0;
    wr(8'h2D, 8'h10);
    cyc(300);
    chk("lock", 25'h0, o_lock_indication);
    i_phase_in_window = 1'b1;
    wait_on(0, 300);
  endtask
  task automatic t_resync();
    logic seen;
    wr(8'h27, 8'h00);
    i_resync_delay_count_low = 16'h0003;
    i_resync_trigger = 1'b1;
    cyc(1);
    i_resync_trigger = 1'b0;
    cyc(1);
    chk("busy", 25'h1, o_resync_busy);
    wait_on(1, 60);
    wr(8'h27, 8'h01);
    i_resync_delay_count_low = 16'h0000;
    i_resync_trigger = 1'b1;
    cyc(1);
    i_resync_trigger = 1'b0;
    seen = 1'b0;
    repeat (2000) begin
      cyc(1);
      seen = seen | o_resync_apply;
    end
    chk("early apply", 25'h0, seen);
    chk("busy", 25'h1, o_resync_busy);
    wr(8'h2A, 8'h10);
    chk("busy", 25'h0, o_resync_busy);
  endtask
  initial begin
    cyc(4);
    i_rst_n = 1'b1;
    cyc(4);
    t_reset();
    t_regs();
    t_power();
    t_sdm();
    t_phase();
    t_gate();
    t_lock();
    t_resync();
    close_out();
  end
endmodule
